// *** rtl/evt_pkg.sv ***
// Package for the sixteen-bit event timer: register map, fields, resets.
// Assumes a byte-wide register port clocked on the peripheral clock.
`default_nettype none
package evt_pkg;
  // ==========================================================
  // Register offsets (byte wide)
  localparam logic [3:0] CONTROL_A_REGISTER_OFS   = 4'h0;
  localparam logic [3:0] CONTROL_B_REGISTER_OFS   = 4'h1;
  localparam logic [3:0] EVENT_CONTROL_REGISTER_OFS  = 4'h4;
  localparam logic [3:0] INTCTRL_OFS = 4'h5;
  localparam logic [3:0] FLAGS_OFS   = 4'h6;
  localparam logic [3:0] STATUS_OFS  = 4'h7;
  localparam logic [3:0] CNTL_OFS    = 4'hA;
  localparam logic [3:0] CNTH_OFS    = 4'hB;
  localparam logic [3:0] CCMPL_OFS   = 4'hC;
  localparam logic [3:0] CCMPH_OFS   = 4'hD;
  // ==========================================================
  // Field positions
  localparam int ENABLE_BIT   = 0;
  localparam int SRC_LSB      = 1;
  localparam int MODE_LSB     = 0;
  localparam int PIN_EN_BIT   = 4;
  localparam int PIN_INIT_BIT = 5;
  localparam int EDGE_BIT     = 4;
  localparam int EVUSE_BIT    = 0;
  localparam int HIT_BIT      = 0;
  localparam int WRAP_BIT     = 1;
  localparam int RUN_BIT      = 0;
  // ==========================================================
  // Values
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL    = 16'hFFFF;
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [15:0] COMPARE_CAPTURE_VALUE_RST   = 16'h0000;
  localparam logic [2:0]  PRESC_LAST = 3'h1;
  localparam logic [2:0]  SRC_DIV1   = 3'h0;
  localparam logic [2:0]  SRC_DIV2   = 3'h1;
  localparam logic [2:0]  SRC_COMP   = 3'h2;
  localparam logic [2:0]  SRC_EVENT  = 3'h7;
  localparam logic [1:0]  MODE_PERIODIC = 2'h0;
  localparam logic [1:0]  MODE_TIMEOUT  = 2'h1;
  localparam logic [1:0]  MODE_CAPTURE  = 2'h2;
  // Timeout check sequence
  typedef enum logic [1:0]
  {
    TO_IDLE = 2'b01,
    TO_RUN  = 2'b10
  } evt_to_state_t;
endpackage
`default_nettype wire

// *** rtl/evt_timer.sv ***
// Sixteen-bit event timer with periodic, time-out and capture modes.
// Assumes an event input and a companion tick from other clock domains.
// Operation
// - Tick from prescaler, companion or event
// - Source select picks prescaler tap, companion or event
// - Companion source follows companion timer ticks
// - Bottom is zero, max is all ones
// - Reset leaves periodic mode selected
// - Enable bit starts counting selected ticks
// - Pin enable drives waveform pin output
// - Periodic: count to top, hit, restart
// - Periodic: top below count wraps at max
// - Timeout: edge starts, next edge freezes
// - Timeout edge polarity follows edge bit
// - Timeout: reaching top raises hit flag
// - Timeout: wrap flag at max, restart
// - Frozen: reads and run writes inert
// - Capture: free run bottom to max
// - Capture: event copies count, flags hit
// - Capture edge rising or falling selectable
// - Capture: low compare read clears hit
// - Capture: wrap flag at max
// - Run status bit readable
`default_nettype none
module evt_timer
  import evt_pkg::*;
(
  input  wire logic       SYS_CLK_IN,
  input  wire logic       SYS_RST_IN,
  input  wire logic       CLK_EN_IN,
  input  wire logic [3:0] REG_ADDR_IN,
  input  wire logic [7:0] REG_WDATA_IN,
  input  wire logic       REG_WR_IN,
  input  wire logic       REG_RD_IN,
  output logic      [7:0] REG_RDATA_OUT,
  input  wire logic       EVENT_IN,
  input  wire logic       COMPANION_TICK_IN,
  input  wire logic       PORT_OUT_IN,
  output logic            WAVEFORM_PIN_OUT,
  output logic            WAVEFORM_PIN_OE_OUT,
  output logic            IRQ_OUT,
  output logic            HIT_EVENT_OUT,
  output logic            WRAP_EVENT_OUT
);
  import evt_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0]    control_a_register_reg;
  logic [7:0]    control_b_register_reg;
  logic [7:0]    event_control_register_reg;
  logic [7:0]    intctrl_reg;
  logic [1:0]    flags_reg;
  logic [15:0]   counter_value_reg;
  logic [15:0]   compare_capture_value_reg;
  logic [7:0]    cnt_hi_tmp_reg;
  logic [7:0]    compare_capture_value_lo_tmp_reg;
  logic [7:0]    rdata_reg;
  logic          wave_reg;
  logic          hit_ev_reg;
  logic          wrap_ev_reg;
  evt_to_state_t to_state_reg;

  logic       enable;
  logic [2:0] tick_source_select;
  logic [1:0] mode;
  logic       edge_sel;
  logic       frozen;
  assign enable             = control_a_register_reg[ENABLE_BIT];
  assign tick_source_select = control_a_register_reg[SRC_LSB +: 3];
  assign mode               = control_b_register_reg[MODE_LSB +: 2];
  assign edge_sel           = event_control_register_reg[EDGE_BIT];
  assign frozen = (mode == MODE_TIMEOUT) && (to_state_reg == TO_IDLE);

  // ==========================================================
  // Input synchronisers, three stages each
  logic [2:0] ev_sync_reg;
  logic [2:0] comp_sync_reg;
  logic       ev_level_reg;
  logic       comp_level_reg;

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      ev_sync_reg    <= 3'h0;
      comp_sync_reg  <= 3'h0;
      ev_level_reg   <= 1'b0;
      comp_level_reg <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      ev_sync_reg   <= {ev_sync_reg[1:0], EVENT_IN};
      comp_sync_reg <= {comp_sync_reg[1:0], COMPANION_TICK_IN};
      // Level moves only when stages two and three agree
      if (ev_sync_reg[1] == ev_sync_reg[2])
        ev_level_reg <= ev_sync_reg[2];
      if (comp_sync_reg[1] == comp_sync_reg[2])
        comp_level_reg <= comp_sync_reg[2];
    end
  end

  logic ev_prev_reg;
  logic comp_prev_reg;
  logic ev_edge;
  logic comp_tick;
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      ev_prev_reg   <= 1'b0;
      comp_prev_reg <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      ev_prev_reg   <= ev_level_reg;
      comp_prev_reg <= comp_level_reg;
    end
  end
  // Event edge polarity chosen by the edge bit; companion tick on rising edge only
  assign ev_edge = edge_sel ? (ev_prev_reg && !ev_level_reg)
                            : (!ev_prev_reg && ev_level_reg);
  assign comp_tick = !comp_prev_reg && comp_level_reg;

  // ==========================================================
  // Tick selection
  logic       presc_reg;
  logic       tick;
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      presc_reg <= 1'b0;
    else if (CLK_EN_IN && enable)
      presc_reg <= ~presc_reg;
  end

  always_comb
  begin
    case (tick_source_select)
      SRC_DIV1:  tick = 1'b1;
      SRC_DIV2:  tick = presc_reg;
      SRC_COMP:  tick = comp_tick;
      // Event as tick is only sensible in periodic mode
      SRC_EVENT: tick = (mode == MODE_PERIODIC) ? ev_edge : 1'b1;
      default:   tick = 1'b1;
    endcase
  end

  // ==========================================================
  // Counter core
  logic running;
  logic at_top;
  logic at_max;
  logic adv;
  logic cnt_wr_lo;
  logic cnt_wr_hi;
  logic compare_capture_value_wr_lo;
  logic capture;
  logic start_ev;
  logic stop_ev;
  assign at_top  = counter_value_reg == compare_capture_value_reg;
  assign at_max  = counter_value_reg == MAX_VAL;
  assign start_ev = (mode == MODE_TIMEOUT) && frozen && ev_edge;
  assign stop_ev  = (mode == MODE_TIMEOUT) && !frozen && ev_edge;
  assign running = enable && !frozen;
  assign adv     = CLK_EN_IN && running && tick;
  assign capture = CLK_EN_IN && enable && (mode == MODE_CAPTURE)
                   && ev_edge;
  assign cnt_wr_lo = REG_WR_IN && REG_ADDR_IN == CNTL_OFS;
  assign cnt_wr_hi = REG_WR_IN && REG_ADDR_IN == CNTH_OFS;
  assign compare_capture_value_wr_lo = REG_WR_IN && REG_ADDR_IN == CCMPL_OFS;

  logic hit_now;
  logic wrap_now;
  always_comb
  begin
    hit_now  = 1'b0;
    wrap_now = 1'b0;
    if (adv)
    begin
      case (mode)
        MODE_PERIODIC, MODE_TIMEOUT:
        begin
          hit_now  = at_top;
          wrap_now = at_max && !at_top;
        end
        MODE_CAPTURE: wrap_now = at_max;
        default: ;
      endcase
    end
    if (capture)
      hit_now = 1'b1;
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      counter_value_reg <= BOTTOM_VAL;
    else if (CLK_EN_IN)
    begin
      // Software write wins over counting
      if (cnt_wr_lo)
        counter_value_reg <= {cnt_hi_tmp_reg, REG_WDATA_IN};
      else if (start_ev && enable)
        counter_value_reg <= BOTTOM_VAL;
      else if (adv)
      begin
        if (mode != MODE_CAPTURE && at_top)
          counter_value_reg <= BOTTOM_VAL;
        else
          counter_value_reg <= counter_value_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      to_state_reg <= TO_IDLE;
    else if (CLK_EN_IN)
    begin
      case (to_state_reg)
        TO_IDLE:
          if (enable && start_ev)
            to_state_reg <= TO_RUN;
        TO_RUN:
          // Disabling drops back to the frozen state
          if (!enable || stop_ev)
            to_state_reg <= TO_IDLE;
        default: to_state_reg <= TO_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      control_a_register_reg   <= REG_RST;
      control_b_register_reg   <= REG_RST;
      event_control_register_reg  <= REG_RST;
      intctrl_reg <= REG_RST;
    end
    else if (CLK_EN_IN && REG_WR_IN)
    begin
      case (REG_ADDR_IN)
        CONTROL_A_REGISTER_OFS:   control_a_register_reg   <= REG_WDATA_IN;
        CONTROL_B_REGISTER_OFS:   control_b_register_reg   <= REG_WDATA_IN;
        EVENT_CONTROL_REGISTER_OFS:  event_control_register_reg  <= REG_WDATA_IN;
        INTCTRL_OFS: intctrl_reg <= REG_WDATA_IN;
        // Run status writes are ignored, frozen or not
        default: ;
      endcase
    end
  end

  // High count byte waits; the low byte write commits the pair
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      cnt_hi_tmp_reg <= REG_RST;
    else if (CLK_EN_IN && cnt_wr_hi)
      cnt_hi_tmp_reg <= REG_WDATA_IN;
  end

  // Low compare byte waits so a half-written TOP never matches
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      compare_capture_value_lo_tmp_reg <= REG_RST;
    else if (CLK_EN_IN && compare_capture_value_wr_lo)
      compare_capture_value_lo_tmp_reg <= REG_WDATA_IN;
  end

  // Compare value: high byte write commits the pair
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      compare_capture_value_reg <= COMPARE_CAPTURE_VALUE_RST;
    else if (CLK_EN_IN)
    begin
      if (capture)
        compare_capture_value_reg <= counter_value_reg;
      else if (REG_WR_IN && REG_ADDR_IN == CCMPH_OFS)
        compare_capture_value_reg <= {REG_WDATA_IN, compare_capture_value_lo_tmp_reg};
    end
  end

  // ==========================================================
  // Flags: set beats clear
  logic ccmpl_rd;
  logic [1:0] flag_clr;
  assign ccmpl_rd = REG_RD_IN && REG_ADDR_IN == CCMPL_OFS;
  always_comb
  begin
    flag_clr = 2'b00;
    if (REG_WR_IN && REG_ADDR_IN == FLAGS_OFS)
      flag_clr = REG_WDATA_IN[1:0];
    // Read of low compare byte clears hit, in capture mode only
    if (ccmpl_rd && mode == MODE_CAPTURE)
      flag_clr[HIT_BIT] = 1'b1;
  end

  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      flags_reg   <= 2'b00;
      hit_ev_reg  <= 1'b0;
      wrap_ev_reg <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      flags_reg[HIT_BIT]  <= hit_now ||
                             (flags_reg[HIT_BIT] && !flag_clr[HIT_BIT]);
      flags_reg[WRAP_BIT] <= wrap_now ||
                             (flags_reg[WRAP_BIT] && !flag_clr[WRAP_BIT]);
      hit_ev_reg  <= hit_now;
      wrap_ev_reg <= wrap_now;
    end
  end
  assign HIT_EVENT_OUT  = hit_ev_reg;
  assign WRAP_EVENT_OUT = wrap_ev_reg;
  assign IRQ_OUT = |(flags_reg & intctrl_reg[1:0]);

  // ==========================================================
  // Waveform: toggles on each hit, initial level from control
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      wave_reg <= 1'b0;
    else if (CLK_EN_IN)
    begin
      if (!enable)
        wave_reg <= control_b_register_reg[PIN_INIT_BIT];
      else if (hit_now)
        wave_reg <= ~wave_reg;
    end
  end
  // Pin enable overrides the port latch
  assign WAVEFORM_PIN_OUT = control_b_register_reg[PIN_EN_BIT] ? wave_reg : PORT_OUT_IN;
  // Pin is always driven, by the port value or the waveform
  assign WAVEFORM_PIN_OE_OUT = 1'b1;

  // ==========================================================
  // Read path, data one cycle after the strobe
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      rdata_reg <= REG_RST;
    else if (CLK_EN_IN)
    begin
      rdata_reg <= REG_RST;
      if (REG_RD_IN)
      begin
        case (REG_ADDR_IN)
          CONTROL_A_REGISTER_OFS:   rdata_reg <= control_a_register_reg;
          CONTROL_B_REGISTER_OFS:   rdata_reg <= control_b_register_reg;
          EVENT_CONTROL_REGISTER_OFS:  rdata_reg <= event_control_register_reg;
          INTCTRL_OFS: rdata_reg <= intctrl_reg;
          FLAGS_OFS:   rdata_reg <= {6'h00, flags_reg};
          STATUS_OFS:  rdata_reg <= {7'h00, running};
          CNTL_OFS:    rdata_reg <= counter_value_reg[7:0];
          CNTH_OFS:    rdata_reg <= counter_value_reg[15:8];
          CCMPL_OFS:   rdata_reg <= compare_capture_value_reg[7:0];
          CCMPH_OFS:   rdata_reg <= compare_capture_value_reg[15:8];
          default:     rdata_reg <= REG_RST;
        endcase
      end
    end
  end
  assign REG_RDATA_OUT = rdata_reg;
endmodule
`default_nettype wire

// *** tb/evt_timer_sva.sv ***
// Port checker for the event timer.
// Assumes the evt_pkg map; bound from the bench top file.
`default_nettype none
module evt_timer_sva
  import evt_pkg::*;
(
  input wire logic       SYS_CLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       CLK_EN_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic       REG_WR_IN,
  input wire logic       REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic       EVENT_IN,
  input wire logic       COMPANION_TICK_IN,
  input wire logic       PORT_OUT_IN,
  input wire logic       WAVEFORM_PIN_OUT,
  input wire logic       WAVEFORM_PIN_OE_OUT,
  input wire logic       IRQ_OUT,
  input wire logic       HIT_EVENT_OUT,
  input wire logic       WRAP_EVENT_OUT
);
  logic       pin_reg;
  logic       en_reg;
  logic [1:0] ien_reg;
  // ==========================================================
  // Shadow of control bits, updated on the same edge as the block
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      pin_reg <= 1'b0;
      en_reg  <= 1'b0;
      ien_reg <= 2'h0;
    end
    else if (REG_WR_IN && CLK_EN_IN)
    begin
      if (REG_ADDR_IN == CONTROL_B_REGISTER_OFS)
        pin_reg <= REG_WDATA_IN[PIN_EN_BIT];
      if (REG_ADDR_IN == CONTROL_A_REGISTER_OFS)
        en_reg <= REG_WDATA_IN[ENABLE_BIT];
      if (REG_ADDR_IN == INTCTRL_OFS)
        ien_reg <= REG_WDATA_IN[1:0];
    end
  end
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ==========================================================
  // Assertions
  oe_on_a: assert property (WAVEFORM_PIN_OE_OUT)
    else $error("pin output enable low");
  pin_mux_a: assert property (
    !pin_reg |-> WAVEFORM_PIN_OUT == PORT_OUT_IN)
    else $error("port value not on pin");
  rdata_idle_a: assert property (
    $past(CLK_EN_IN) && !$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
    else $error("read data without read");
  hit_enabled_a: assert property (
    $rose(HIT_EVENT_OUT) |-> $past(en_reg))
    else $error("hit event while disabled");
  wrap_pulse_a: assert property (
    WRAP_EVENT_OUT && CLK_EN_IN |=> !WRAP_EVENT_OUT [*8])
    else $error("wrap event repeats");
  irq_masked_a: assert property (ien_reg == 2'h0 |-> !IRQ_OUT)
    else $error("irq while masked");
  hit_irq_a: assert property (HIT_EVENT_OUT && ien_reg[0] |-> IRQ_OUT)
    else $error("hit without irq");
  wrap_irq_a: assert property (
    WRAP_EVENT_OUT && ien_reg[1] |-> IRQ_OUT)
    else $error("wrap without irq");
  idle_quiet_a: assert property (!en_reg && !$past(en_reg)
    |-> !HIT_EVENT_OUT && !WRAP_EVENT_OUT)
    else $error("event while disabled");
endmodule
`default_nettype wire

// *** tb/evt_far_end.sv ***
// Far side: event channel and free running companion timer clock.
// Assumes the bench picks auto pulses or a held event level.
`default_nettype none
module evt_far_end
#(
  parameter int COMP_DIV = 8,
  parameter int EV_GAP   = 10
)
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic auto_in,
  input  wire logic level_in,
  output logic      event_out,
  output logic      comp_tick_out
);
  int comp_cnt;
  int ev_cnt;
  // ==========================================================
  // Counters for both sources
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      comp_cnt <= 0;
      ev_cnt   <= 0;
    end
    else
    begin
      comp_cnt <= (comp_cnt + 1) % COMP_DIV;
      ev_cnt   <= auto_in ? (ev_cnt + 1) % EV_GAP : 0;
    end
  end
  assign comp_tick_out = (comp_cnt < COMP_DIV / 2);
  // Three cycles high so the sync never drops a pulse
  assign event_out = auto_in ? (ev_cnt < 3) : level_in;
endmodule
`default_nettype wire

// *** tb/tb_evt_timer.sv ***
// Bench for the event timer, driven over its register port.
// Assumes evt_far_end feeds the event and companion inputs.
`default_nettype none
module tb_evt_timer;
  timeunit 1ns;
  timeprecision 100ps;
  import evt_pkg::*;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdat = 8'h00;
  logic        wr   = 1'b0;
  logic        rd   = 1'b0;
  logic        cen  = 1'b1;
  logic        port = 1'b0;
  logic        auto_ev = 1'b0;
  logic        lvl  = 1'b0;
  logic [7:0]  d;
  logic [15:0] c;
  wire  logic [7:0] rdat;
  wire  logic  pin, irq, hit, wrap, ev, comp;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          t;
  always #12.5 clk = ~clk;
  evt_timer dut_u
  (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(cen),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdat), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .EVENT_IN(ev),
    .COMPANION_TICK_IN(comp), .PORT_OUT_IN(port),
    .WAVEFORM_PIN_OUT(pin), .WAVEFORM_PIN_OE_OUT(), .IRQ_OUT(irq),
    .HIT_EVENT_OUT(hit), .WRAP_EVENT_OUT(wrap)
  );
  evt_far_end far_u
  (
    .clk_in(clk), .rst_in(rst), .auto_in(auto_ev), .level_in(lvl),
    .event_out(ev), .comp_tick_out(comp)
  );
  // ==========================================================
  // Register port and checking tasks
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdat <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    x = rdat;
  endtask
  task automatic chk(input logic [15:0] g, e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Edges until the chosen event pulse, bounded
  task automatic wait_ev(input logic w, input int lim, output int n);
    for (n = 1; n <= lim; n++)
    begin
      @(posedge clk);
      #1;
      if ((w ? wrap : hit) === 1'b1)
        return;
    end
    fail_count++;
    $display("[FAIL] %0t event wait ran out", $time);
    summarize();
  endtask
  task automatic set16(input logic [3:0] a1, a2, input logic [15:0] v);
    wr_reg(a1, (a1 == CNTH_OFS) ? v[15:8] : v[7:0]);
    wr_reg(a2, (a2 == CNTL_OFS) ? v[7:0] : v[15:8]);
  endtask
  task automatic per(input logic [2:0] s, input int p);
    wr_reg(CONTROL_A_REGISTER_OFS, {4'h0, s, 1'b1});
    wait_ev(1'b0, 4 * p + 40, t);
    wait_ev(1'b0, 2 * p, t);
    chk(16'(t), 16'(p), "hit period");
    wr_reg(CONTROL_A_REGISTER_OFS, 8'h00);
  endtask
  task automatic evp();
    lvl <= 1'b1;
    repeat (3) @(posedge clk);
    lvl <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(CONTROL_B_REGISTER_OFS, d);
    chk(d, 16'h0000, "mode");
    rd_reg(STATUS_OFS, d);
    chk(d, 16'h0000, "status");
    rd_reg(CNTL_OFS, d);
    chk(d, BOTTOM_VAL, "count");
    rd_reg(4'h3, d);
    chk(d, 16'h0000, "unmapped");
    wr_reg(CONTROL_B_REGISTER_OFS, 8'h30);
    @(posedge clk);
    port <= 1'b1;
    #1 chk(pin, 16'h1, "pin init");
    wr_reg(CONTROL_B_REGISTER_OFS, 8'h10);
    @(posedge clk);
    #1 chk(pin, 16'h0, "pin over port");
    wr_reg(CONTROL_B_REGISTER_OFS, 8'h00);
    #1 chk(pin, 16'h1, "port on pin");
    $display("test pin done");
    wr_reg(INTCTRL_OFS, 8'h03);
    wr_reg(EVENT_CONTROL_REGISTER_OFS, 8'h01);
    set16(CCMPL_OFS, CCMPH_OFS, 16'h0005);
    per(SRC_DIV1, 6);
    #1 chk(irq, 16'h1, "irq");
    wr_reg(FLAGS_OFS, 8'h03);
    #1 chk(irq, 16'h0, "irq clear");
    per(SRC_DIV2, 12);
    per(SRC_COMP, 48);
    auto_ev <= 1'b1;
    per(SRC_EVENT, 60);
    auto_ev <= 1'b0;
    set16(CNTH_OFS, CNTL_OFS, 16'hFFF0);
    wr_reg(CONTROL_A_REGISTER_OFS, 8'h01);
    wait_ev(1'b1, 40, t);
    wait_ev(1'b0, 10, t);
    chk(16'(t), 16'h0006, "restart");
    $display("test periodic done");
    wr_reg(CONTROL_A_REGISTER_OFS, 8'h00);
    wr_reg(CONTROL_B_REGISTER_OFS, {6'h00, MODE_TIMEOUT});
    set16(CCMPL_OFS, CCMPH_OFS, 16'h0040);
    wr_reg(CONTROL_A_REGISTER_OFS, 8'h0F);
    evp();
    rd_reg(STATUS_OFS, d);
    chk(d, 16'h1, "running");
    repeat (10) @(posedge clk);
    evp();
    rd_reg(STATUS_OFS, d);
    chk(d, 16'h0, "frozen");
    rd_reg(CNTL_OFS, d);
    c = 16'(d);
    wr_reg(STATUS_OFS, 8'h01);
    rd_reg(CNTL_OFS, d);
    chk(d, c, "held count");
    evp();
    wait_ev(1'b0, 120, t);
    evp();
    $display("test timeout done");
    wr_reg(CONTROL_A_REGISTER_OFS, 8'h00);
    wr_reg(CONTROL_B_REGISTER_OFS, {6'h00, MODE_CAPTURE});
    set16(CNTH_OFS, CNTL_OFS, 16'h0000);
    wr_reg(EVENT_CONTROL_REGISTER_OFS, 8'h11);
    wr_reg(FLAGS_OFS, 8'h03);
    wr_reg(CONTROL_A_REGISTER_OFS, 8'h0F);
    lvl <= 1'b1;
    repeat (15) @(posedge clk);
    rd_reg(FLAGS_OFS, d);
    chk(d[0], 16'h0, "rise ignored");
    lvl <= 1'b0;
    wait_ev(1'b0, 20, t);
    rd_reg(CCMPL_OFS, d);
    c[7:0] = d;
    rd_reg(CCMPH_OFS, d);
    c[15:8] = d;
    chk(16'(c > 16'h10 && c < 16'h60), 16'h1, "capture");
    rd_reg(FLAGS_OFS, d);
    chk(d[0], 16'h0, "hit cleared");
    set16(CNTH_OFS, CNTL_OFS, 16'hFFF8);
    wait_ev(1'b1, 40, t);
    rd_reg(CNTL_OFS, d);
    chk(16'(d < 8'h20), 16'h1, "wrapped");
    c[7:0] = d;
    @(posedge clk);
    cen <= 1'b0;
    repeat (10) @(posedge clk);
    cen <= 1'b1;
    rd_reg(CNTL_OFS, d);
    d = d - c[7:0];
    chk(d, 16'h0003, "held while clock enable low");
    $display("test capture done");
    summarize();
  end
endmodule
bind evt_timer evt_timer_sva chk_u
(
  .SYS_CLK_IN, .SYS_RST_IN, .CLK_EN_IN, .REG_ADDR_IN, .REG_WDATA_IN,
  .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .EVENT_IN, .COMPANION_TICK_IN,
  .PORT_OUT_IN, .WAVEFORM_PIN_OUT, .WAVEFORM_PIN_OE_OUT, .IRQ_OUT,
  .HIT_EVENT_OUT, .WRAP_EVENT_OUT
);
`default_nettype wire
